// File: fomc_pkg.sv
// Constants shared by the overlay controller and its pin sequencer.
// Assumes a 16-bit parallel flash reached word-wise, with software on APB.
package fomc_pkg;
	localparam int DATA_W = 16;
	localparam int APB_AW = 8;

	// Own register map, byte addresses
	localparam logic [APB_AW-1:0] REG_CTRL   = 8'h00;
	localparam logic [APB_AW-1:0] REG_ADDR   = 8'h04;
	localparam logic [APB_AW-1:0] REG_WDATA  = 8'h08;
	localparam logic [APB_AW-1:0] REG_RDATA  = 8'h0C;
	localparam logic [APB_AW-1:0] REG_STATUS = 8'h10;

	// Operations written to CTRL[2:0]
	typedef enum logic [2:0] {
		OP_READ       = 3'h0,
		OP_WRITE      = 3'h1,
		OP_CFI_ENTER  = 3'h2,
		OP_EXIT       = 3'h3,
		OP_STATUS_CMD = 3'h4,
		OP_OVL_ENTER  = 3'h5
	} fomc_op_t;

	// Overlay the controller believes the flash is in
	typedef enum logic [1:0] {
		MAP_READ   = 2'h0,
		MAP_CFI    = 2'h1,
		MAP_OTHER  = 2'h2,
		MAP_STATUS = 2'h3
	} fomc_map_t;

	// Command words and offsets
	localparam logic [DATA_W-1:0] CMD_CFI_ENTRY = 16'h0098;
	localparam logic [DATA_W-1:0] CMD_EXIT      = 16'h00F0;
	localparam logic [15:0]       OFS_CFI_ENTRY = 16'h0055;
	localparam logic [15:0]       OFS_EXIT      = 16'h0000;
	localparam logic [15:0]       OFS_PROT      = 16'h0002;
	localparam int                PROT_BIT      = 0;

	// STATUS fields and the CTRL operation field width
	localparam int ST_BUSY  = 0;
	localparam int ST_MAP   = 1;
	localparam int ST_PROT  = 3;
	localparam int ST_RDY   = 4;
	localparam int ST_ERR   = 5;
	localparam int CTRL_OPW = 3;

	// Pin timing, nanoseconds, and the clock period
	localparam int CLK_NS    = 5;
	localparam int T_ACC_NS  = 100;
	localparam int T_WP_NS   = 50;
	localparam int T_WPH_NS  = 30;
	localparam int ACC_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WPH_CYC   = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W     = 8;

	typedef enum logic [1:0] {
		PS_IDLE  = 2'b00,
		PS_SETUP = 2'b01,
		PS_STRB  = 2'b11,
		PS_HOLD  = 2'b10
	} fomc_pin_t;
endpackage : fomc_pkg

// File: fomc_pins.sv
// One asynchronous flash bus cycle, read or write, timed in mclk cycles.
// Assumes the flash data pins are resolved outside from dq_o and dq_oe.
`timescale 1ns/1ps
module fomc_pins #(
	parameter int ADDR_W = 25
) (
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	input  wire logic                        start,
	input  wire logic                        is_write,
	input  wire logic [ADDR_W-1:0]           addr,
	input  wire logic [fomc_pkg::DATA_W-1:0] wdata,
	output logic                             done,
	output logic [fomc_pkg::DATA_W-1:0]      rdata,
	output logic [ADDR_W-1:0]                fl_addr,
	input  wire logic [fomc_pkg::DATA_W-1:0] dq_i,
	output logic [fomc_pkg::DATA_W-1:0]      dq_o,
	output logic                             dq_oe,
	output logic                             ce_n,
	output logic                             oe_n,
	output logic                             we_n
);
	import fomc_pkg::*;

	fomc_pin_t        st_q;
	logic [CNT_W-1:0] cnt_q;
	logic             wr_q;

	initial begin
		if (ACC_CYC >= 2**CNT_W || WP_CYC >= 2**CNT_W || WPH_CYC >= 2**CNT_W)
			$error("fomc_pins: timing count exceeds counter");
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_q    <= PS_IDLE;
			cnt_q   <= '0;
			wr_q    <= 1'b0;
			done    <= 1'b0;
			rdata   <= '0;
			fl_addr <= '0;
			dq_o    <= '0;
			dq_oe   <= 1'b0;
			ce_n    <= 1'b1;
			oe_n    <= 1'b1;
			we_n    <= 1'b1;
		end else begin
			done <= 1'b0;
			case (st_q)
				PS_IDLE: begin
					if (start) begin
						fl_addr <= addr;
						dq_o    <= wdata;
						dq_oe   <= is_write;
						wr_q    <= is_write;
						ce_n    <= 1'b0;
						st_q    <= PS_SETUP;
					end
				end
				PS_SETUP: begin
					we_n  <= ~wr_q;
					oe_n  <= wr_q;
					cnt_q <= wr_q ? CNT_W'(WP_CYC) : CNT_W'(ACC_CYC);
					st_q  <= PS_STRB;
				end
				PS_STRB: begin
					if (cnt_q > CNT_W'(1)) begin
						cnt_q <= cnt_q - CNT_W'(1);
					end else begin
						// Rising strobe edge: write latched, or read ends
						if (!wr_q)
							rdata <= dq_i;
						we_n  <= 1'b1;
						oe_n  <= 1'b1;
						ce_n  <= 1'b1;
						cnt_q <= CNT_W'(WPH_CYC);
						st_q  <= PS_HOLD;
					end
				end
				PS_HOLD: begin
					dq_oe <= 1'b0;
					if (cnt_q > CNT_W'(1)) begin
						cnt_q <= cnt_q - CNT_W'(1);
					end else begin
						done <= 1'b1;
						st_q <= PS_IDLE;
					end
				end
				default: st_q <= PS_IDLE;
			endcase
		end
	end
endmodule : fomc_pins

// File: fomc_ctrl.sv
// Host controller that steers a parallel NOR flash through its overlay modes.
// Assumes software on APB and one flash wired to the pin ports below.
//
// Notes on behaviour
// - Identification overlay entry only from read mode; entry sector picks overlay.
// - Protection state valid only for entry sector; re-enter to query another.
// - Identification entry writes 0x0098 at word offset 0x55.
// - Identification exit writes 0x00F0 at word offset zero.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
module fomc_ctrl #(
	parameter int ADDR_W = 25,
	parameter int SECT_LSB = 16
) (
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [fomc_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr,
	output logic [ADDR_W-1:0]                fl_addr,
	input  wire logic [fomc_pkg::DATA_W-1:0] dq_i,
	output logic [fomc_pkg::DATA_W-1:0]      dq_o,
	output logic                             dq_oe,
	output logic                             ce_n,
	output logic                             oe_n,
	output logic                             we_n,
	input  wire logic                        ready_busy_n
);
	import fomc_pkg::*;

	localparam int SECT_W = ADDR_W - SECT_LSB;

	initial begin
		if (SECT_LSB < 3 || SECT_LSB >= ADDR_W || ADDR_W > 32)
			$error("fomc_ctrl: unsupported address split");
	end

	logic [ADDR_W-1:0]  addr_q;
	logic [DATA_W-1:0]  wdata_q;
	logic [DATA_W-1:0]  rdata_q;
	fomc_map_t          map_q;
	fomc_map_t          saved_q;
	logic [SECT_W-1:0]  sect_q;
	logic               prot_q;
	logic               err_q;
	logic               busy_q;
	fomc_op_t           op_q;
	logic               start_q;
	logic               cyc_wr_q;
	logic [ADDR_W-1:0]  cyc_addr_q;
	logic [DATA_W-1:0]  cyc_data_q;
	logic               pin_done;
	logic [DATA_W-1:0]  pin_rdata;
	logic               wr_acc;
	logic               go;
	logic               refuse;
	fomc_op_t           go_op;

	function automatic logic [SECT_W-1:0] sect_of(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:SECT_LSB];
	endfunction : sect_of

	function automatic logic [ADDR_W-1:0] word_at(input logic [SECT_W-1:0] s,
	                                             input logic [15:0] ofs);
		return {s, SECT_LSB'(ofs)};
	endfunction : word_at

	// APB slave, answers with no wait state
	assign pready  = 1'b1;
	assign wr_acc  = psel && penable && pwrite;
	assign go      = wr_acc && (paddr == REG_CTRL) && !busy_q;
	assign go_op   = fomc_op_t'(pwdata[CTRL_OPW-1:0]);
	assign pslverr = psel && penable && !(paddr == REG_CTRL || paddr == REG_ADDR ||
	                 paddr == REG_WDATA || paddr == REG_RDATA || paddr == REG_STATUS);

	// Entries only from read mode; reset refused while the algorithm runs
	always_comb begin
		refuse = 1'b0;
		if ((go_op == OP_CFI_ENTER || go_op == OP_OVL_ENTER) && map_q != MAP_READ)
			refuse = 1'b1;
		if (go_op == OP_EXIT && !ready_busy_n)
			refuse = 1'b1;
		if (go_op > OP_OVL_ENTER)
			refuse = 1'b1;
	end

	always_comb begin
		prdata = '0;
		if (psel && !pwrite) begin
			case (paddr)
				REG_CTRL:   prdata = {29'h0000_000, op_q};
				REG_ADDR:   prdata = 32'(addr_q);
				REG_WDATA:  prdata = {16'h0000, wdata_q};
				REG_RDATA:  prdata = {16'h0000, rdata_q};
				REG_STATUS: prdata = {26'h000_0000, err_q, ready_busy_n, prot_q,
				                      map_q, busy_q};
				default:    prdata = '0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			addr_q  <= '0;
			wdata_q <= '0;
		end else begin
			if (wr_acc && paddr == REG_ADDR)
				addr_q <= pwdata[ADDR_W-1:0];
			if (wr_acc && paddr == REG_WDATA)
				wdata_q <= pwdata[DATA_W-1:0];
		end
	end

	// Refused requests and out-of-sector protection-word reads raise a sticky error; set wins over clear
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			err_q <= 1'b0;
		end else if (go && refuse) begin
			err_q <= 1'b1;
		end else if (go && go_op == OP_READ && map_q == MAP_CFI &&
		             addr_q[SECT_LSB-1:0] == SECT_LSB'(OFS_PROT) &&
		             sect_of(addr_q) != sect_q) begin
			err_q <= 1'b1;
		end else if (wr_acc && paddr == REG_STATUS && pwdata[ST_ERR]) begin
			err_q <= 1'b0;
		end
	end

	// Launch one flash bus cycle per accepted operation
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			busy_q     <= 1'b0;
			op_q       <= OP_READ;
			start_q    <= 1'b0;
			cyc_wr_q   <= 1'b0;
			cyc_addr_q <= '0;
			cyc_data_q <= '0;
		end else begin
			start_q <= 1'b0;
			if (go && !refuse) begin
				busy_q     <= 1'b1;
				op_q       <= go_op;
				start_q    <= 1'b1;
				cyc_wr_q   <= go_op != OP_READ;
				cyc_addr_q <= addr_q;
				cyc_data_q <= wdata_q;
				case (go_op)
					OP_CFI_ENTER: begin
						cyc_addr_q <= word_at(sect_of(addr_q), OFS_CFI_ENTRY);
						cyc_data_q <= CMD_CFI_ENTRY;
					end
					OP_EXIT: begin
						// Common exit doubles as soft reset; from status it only sets the saved map to read
						cyc_addr_q <= word_at(sect_of(addr_q), OFS_EXIT);
						cyc_data_q <= CMD_EXIT;
					end
					default: begin
					end
				endcase
			end else if (pin_done) begin
				busy_q <= 1'b0;
			end
		end
	end

	// Track which map the flash presents, mirrored at each completed cycle
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			map_q   <= MAP_READ;
			saved_q <= MAP_READ;
			sect_q  <= '0;
			prot_q  <= 1'b0;
			rdata_q <= '0;
		end else if (pin_done) begin
			case (op_q)
				OP_READ: begin
					rdata_q <= pin_rdata;
					if (map_q == MAP_STATUS)
						map_q <= saved_q;
					else if (map_q == MAP_CFI &&
					         cyc_addr_q[SECT_LSB-1:0] == SECT_LSB'(OFS_PROT) &&
					         sect_of(cyc_addr_q) == sect_q)
						prot_q <= pin_rdata[PROT_BIT];
				end
				OP_CFI_ENTER: begin
					map_q  <= MAP_CFI;
					sect_q <= sect_of(cyc_addr_q);
				end
				OP_OVL_ENTER: begin
					map_q  <= MAP_OTHER;
					sect_q <= sect_of(cyc_addr_q);
				end
				OP_STATUS_CMD: begin
					if (map_q != MAP_STATUS)
						saved_q <= map_q;
					map_q <= MAP_STATUS;
				end
				OP_EXIT: begin
					if (map_q == MAP_STATUS)
						saved_q <= MAP_READ;
					else
						map_q <= MAP_READ;
				end
				default: begin
					// Plain writes keep the overlay, unlock and erase included
				end
			endcase
		end
	end

	fomc_pins #(
		.ADDR_W(ADDR_W)
	) u_pins (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.start    (start_q),
		.is_write (cyc_wr_q),
		.addr     (cyc_addr_q),
		.wdata    (cyc_data_q),
		.done     (pin_done),
		.rdata    (pin_rdata),
		.fl_addr  (fl_addr),
		.dq_i     (dq_i),
		.dq_o     (dq_o),
		.dq_oe    (dq_oe),
		.ce_n     (ce_n),
		.oe_n     (oe_n),
		.we_n     (we_n)
	);
endmodule : fomc_ctrl

// File: fomc_ctrl_sva.sv
// Checker of the overlay controller's APB answer and flash strobe shapes.
// Bound to fomc_ctrl; sees only its ports.
`timescale 1ns/1ps
module fomc_ctrl_sva #(
	parameter int ADDR_W = 25
) (
	input wire logic                        mclk,
	input wire logic                        rst_n,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic [fomc_pkg::APB_AW-1:0] paddr,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire logic [ADDR_W-1:0]           fl_addr,
	input wire logic [fomc_pkg::DATA_W-1:0] dq_o,
	input wire logic                        dq_oe,
	input wire logic                        ce_n,
	input wire logic                        oe_n,
	input wire logic                        we_n
);
	import fomc_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_apb_no_wait: assert property (pready)
		else $error("pready low");
	a_err_unmapped: assert property (psel && penable && paddr > REG_STATUS |-> pslverr)
		else $error("unmapped access not flagged");
	a_err_phase: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	a_wr_width: assert property ($fell(we_n) |-> ##9 !we_n ##1 we_n)
		else $error("write strobe length wrong");
	a_rd_width: assert property ($fell(oe_n) |-> ##19 !oe_n ##1 oe_n)
		else $error("read strobe length wrong");
	a_strobe_framed: assert property (!we_n || !oe_n |-> !ce_n && (we_n || oe_n))
		else $error("strobe outside select");
	a_wr_hold: assert property (!we_n |-> dq_oe && $stable(dq_o) && $stable(fl_addr))
		else $error("write word moved under strobe");
	a_rd_float: assert property (!oe_n |-> !dq_oe)
		else $error("data driven during read");
	a_setup_first: assert property ($fell(ce_n) |=> we_n != oe_n)
		else $error("no strobe after select");
	a_wr_release: assert property ($rose(we_n) |-> ce_n && dq_oe ##1 !dq_oe)
		else $error("write release order wrong");
	a_end_gap: assert property ($rose(ce_n) |-> ce_n[*7])
		else $error("select gap too short");
endmodule : fomc_ctrl_sva

bind fomc_ctrl fomc_ctrl_sva #(.ADDR_W(ADDR_W)) u_sva (.mclk(mclk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.fl_addr(fl_addr), .dq_o(dq_o), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));

// File: fomc_flash_model.sv
// Behavioural flash: read, identification, status and persistent overlays.
// Assumes strobes from fomc_ctrl; four sectors decoded above SECT_LSB.
`timescale 1ns/1ps
module fomc_flash_model #(
	parameter int SECT_LSB = 16
) (
	input  wire logic [24:0] fl_addr,
	input  wire logic [15:0] dq_o,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	output logic      [15:0] dq_i,
	output logic             ready_busy_n
);
	// Map codes: 0 array, 1 identification, 2 persistent bits, 3 status
	logic [1:0]  map_q = 2'h0;
	logic [1:0]  back_q = 2'h0;
	logic [1:0]  ent_q = 2'h0;
	logic [3:0]  pers_q = 4'hF;
	logic [3:0]  dyn_q = 4'hB;
	logic [15:0] stat_q = 16'h0000;
	logic [15:0] last_q = 16'h0000;
	logic [15:0] rd;
	wire  [1:0]  sec = fl_addr[SECT_LSB+1:SECT_LSB];
	wire  [15:0] ofs = fl_addr[15:0];
	initial ready_busy_n = 1'b1;
	always @(posedge we_n) begin
		if (dq_o == 16'h00F0 && ready_busy_n) begin
			if (map_q == 2'h3) back_q <= 2'h0;
			else map_q <= 2'h0;
		end else if (dq_o == 16'h0098 && map_q == 2'h0) begin
			map_q <= 2'h1;
			ent_q <= sec;
		end else if (dq_o == 16'h0070) begin
			stat_q <= {8'h00, ready_busy_n, 7'h00};
			if (map_q != 2'h3) back_q <= map_q;
			map_q <= 2'h3;
		end else if (dq_o == 16'h00C0 && map_q == 2'h0) map_q <= 2'h2;
		else if (dq_o == 16'h0000 && map_q == 2'h2) pers_q[sec] <= 1'b0;
		else if (dq_o == 16'h0030 && map_q == 2'h2) pers_q <= 4'hF;
		else if (dq_o == 16'h00A0 && map_q == 2'h0) begin
			ready_busy_n <= 1'b0;
			ready_busy_n <= #400 1'b1;
		end
	end
	always @(posedge oe_n) begin
		last_q <= rd;
		if (map_q == 2'h3) map_q <= back_q;
	end
	always_comb begin
		case (map_q)
			2'h0: rd = ~ofs;
			2'h1: rd = (ofs == 16'h0002 && sec == ent_q) ? {15'h0, ~(pers_q[sec] & dyn_q[sec])}
				: ~last_q;
			2'h2: rd = {15'h0, pers_q[sec]};
			default: rd = stat_q;
		endcase
	end
	// Released bus shows the inverse of the last word, never a held value
	assign dq_i = (!ce_n && !oe_n) ? rd : ~last_q;
endmodule : fomc_flash_model

// File: flash_overlay_mode_control_tb.sv
// Testbench: APB operations on fomc_ctrl against the behavioural flash.
// Assumes fomc_pkg, fomc_flash_model and fomc_ctrl_sva compiled first.
`timescale 1ns/1ps
module flash_overlay_mode_control_tb;
	import fomc_pkg::*;
	logic        mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic        pready, pslverr, dq_oe, ce_n, oe_n, we_n, ready_busy_n, perr;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic [24:0] fl_addr;
	logic [15:0] dq_i, dq_o;
	int          fail_count = 0, checks_done = 0;
	always #2.5 mclk = ~mclk;
	fomc_ctrl dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fl_addr(fl_addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
		.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .ready_busy_n(ready_busy_n));
	fomc_flash_model u_flash (.fl_addr(fl_addr), .dq_o(dq_o), .ce_n(ce_n), .oe_n(oe_n),
		.we_n(we_n), .dq_i(dq_i), .ready_busy_n(ready_busy_n));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fail_count++;
			tally_and_finish();
		end
		@(posedge mclk);
	endtask : apb
	task automatic op(input logic [2:0] c, input logic [24:0] a, input logic [15:0] d);
		int n;
		n = 0;
		apb(1'b1, REG_ADDR, {7'h0, a});
		apb(1'b1, REG_WDATA, {16'h0, d});
		apb(1'b1, REG_CTRL, {29'h0, c});
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (q[ST_BUSY] !== 1'b0 && n < 40);
		if (q[ST_BUSY] !== 1'b0) begin
			fail_count++;
			tally_and_finish();
		end
	endtask : op
	task automatic rd(input logic [24:0] a, input logic [15:0] e, input string nm);
		op(OP_READ, a, 16'h0);
		apb(1'b0, REG_RDATA, 32'h0);
		chk(nm, {16'h0, e}, q);
	endtask : rd
	task automatic map_is(input fomc_map_t m);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("map", {30'h0, m}, {30'h0, q[ST_MAP+1:ST_MAP]});
	endtask : map_is
	// Checks the error flag, then clears it by writing one
	task automatic err_is(input logic e);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("err", {31'h0, e}, {31'h0, q[ST_ERR]});
		apb(1'b1, REG_STATUS, 32'h0000_0020);
	endtask : err_is
	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status_reset", 32'h0000_0010, q);
		rd(25'h000_0123, 16'hFEDC, "array");
		op(OP_CFI_ENTER, 25'h002_0000, 16'h0);
		map_is(MAP_CFI);
		rd(25'h002_0002, 16'h0001, "prot_s2");
		apb(1'b0, REG_STATUS, 32'h0);
		chk("prot_bit", 32'h1, {31'h0, q[ST_PROT]});
		err_is(1'b0);
		op(OP_READ, 25'h000_0002, 16'h0);
		err_is(1'b1);
		op(OP_CFI_ENTER, 25'h0, 16'h0);
		err_is(1'b1);
		op(OP_STATUS_CMD, 25'h0, 16'h0070);
		map_is(MAP_STATUS);
		op(OP_WRITE, 25'h5, 16'h1234);
		map_is(MAP_STATUS);
		rd(25'h1_2345, 16'h0080, "status_word");
		map_is(MAP_CFI);
		op(OP_EXIT, 25'h0, 16'h0);
		map_is(MAP_READ);
		op(OP_OVL_ENTER, 25'h0, 16'h00C0);
		map_is(MAP_OTHER);
		op(OP_WRITE, 25'h0_0007, 16'h0000);
		rd(25'h0_0005, 16'h0000, "pers_s0");
		rd(25'h1_0005, 16'h0001, "pers_s1");
		op(OP_EXIT, 25'h0, 16'h0);
		op(OP_CFI_ENTER, 25'h0, 16'h0);
		rd(25'h0_0002, 16'h0001, "prot_s0");
		op(OP_EXIT, 25'h0, 16'h0);
		op(OP_OVL_ENTER, 25'h0, 16'h00C0);
		op(OP_WRITE, 25'h0, 16'h0030);
		map_is(MAP_OTHER);
		rd(25'h0_0009, 16'h0001, "pers_erased");
		op(OP_EXIT, 25'h0, 16'h0);
		map_is(MAP_READ);
		op(OP_WRITE, 25'h0, 16'h00A0);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("ready", 32'h0, {31'h0, q[ST_RDY]});
		op(OP_EXIT, 25'h0, 16'h0);
		err_is(1'b1);
		op(3'h7, 25'h0, 16'h0);
		err_is(1'b1);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl_op", {29'h0, OP_WRITE}, q);
		apb(1'b0, 8'h14, 32'h0);
		chk("slverr", 32'h1, {31'h0, perr});
		tally_and_finish();
	end
endmodule : flash_overlay_mode_control_tb
